/* common/rmsfc_pkg.sv */
// package for the radio mode, synthesizer and buffer control block
// assumes a single core clock plus a link bit clock from the modem
package rmsfc_pkg;
    typedef enum logic [2:0] {
        RMSFC_SLEEP   = 3'h0,
        RMSFC_STANDBY = 3'h1,
        RMSFC_SYNTH   = 3'h2,
        RMSFC_RECV    = 3'h3,
        RMSFC_XMIT    = 3'h4
    } rmsfc_mode_type;

    typedef enum logic [1:0] {
        RMSFC_CONT   = 2'h0,
        RMSFC_BUFF   = 2'h1,
        RMSFC_PACKET = 2'h2
    } rmsfc_dmode_type;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] p;
        logic [7:0] s;
    } rmsfc_div_set_type;

    typedef struct packed {
        logic xtal;
        logic synth;
        logic recv;
        logic xmit;
    } rmsfc_pwr_type;

    localparam logic [2:0]  BAND_LAST     = 3'h5;
    localparam logic [7:0]  R_MIN         = 8'h40;
    localparam logic [7:0]  R_MAX         = 8'ha9;
    localparam logic [15:0] P_MULT        = 16'h004b;
    localparam int          IF_LO_RATIO   = 8;
    localparam logic [6:0]  DEPTH_STEP    = 7'h10;
    localparam int          FIFO_WORDS    = 64;
    localparam int          BITS_PER_BYTE = 8;
    localparam logic [2:0]  RST_MODE      = 3'h0;
    localparam logic [1:0]  RST_DMODE     = 2'h0;
endpackage

/* design/rmsfc_ctrl.sv */
// mode decode, synthesizer divider selection, lock status and data buffer
// assumes control bits come from a host port decoder on core_clk_i and
// received bits arrive on link_clk_i from the demodulator
// Functional notes
// [RQ1] band code selects one of six ranges
// [RQ2] quarter code picks one band quarter
// [RQ3] lo equals crystal times divider ratio
// [RQ4] intermediate frequency is lo over eight
// [RQ5] two divider sets, one select bit
// [RQ6] host reloads idle set, then flips select
// [RQ7] lock pin high when locked and enabled
// [RQ8] lock status sticky until written one
// [RQ9] mode code selects five power states
// [RQ10] each mode enables its listed functions
// [RQ11] pin directions follow the chip mode
// [RQ12] serial out driven only while selected
// [RQ13] config select wins over buffer select
// [RQ14] continuous mode bits bypass the buffer
// [RQ15] buffered mode stores bytes, host accesses
// [RQ16] packet mode frames through the buffer
// [RQ17] data pin bidirectional by direction
// [RQ18] depth field sets 16 to 64 bytes
// [RQ19] rx level event when count >= threshold
// [RQ20] tx level event when count <= threshold
// [RQ21] nonempty and full indications provided
// [RQ22] handling code 00 is continuous
// [RQ23] handling code 01 is buffered
// [RQ24] full at working depth, nonempty when nonzero
// [RQ25] mode write acts on next clock; power and pin enables here change only on the second clock
`timescale 1ns/1ps
`default_nettype none
module rmsfc_ctrl #(
    parameter int DEPTH = rmsfc_pkg::FIFO_WORDS
) (
    // clocks and reset
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        link_clk_i,
    // configuration
    input  wire logic [2:0]                  chip_level_mode_i,
    input  wire logic [1:0]                  data_handling_mode_i,
    input  wire logic [2:0]                  vco_band_select_i,
    input  wire logic [1:0]                  vco_quarter_select_i,
    input  wire rmsfc_pkg::rmsfc_div_set_type div_set_a_i,
    input  wire rmsfc_pkg::rmsfc_div_set_type div_set_b_i,
    input  wire logic                        divider_set_select_i,
    input  wire logic                        lock_pin_enable_i,
    input  wire logic                        lock_status_clear_i,
    input  wire logic [1:0]                  buffer_working_depth_i,
    input  wire logic [5:0]                  buffer_level_threshold_i,
    // synthesizer
    input  wire logic                        pll_lock_raw_i,
    output logic [5:0]                       band_onehot_o,
    output logic [3:0]                       quarter_onehot_o,
    output rmsfc_pkg::rmsfc_div_set_type     active_div_o,
    output logic [15:0]                      fb_ratio_o,
    output logic                             div_range_ok_o,
    output logic                             lock_status_latch_o,
    output logic                             lock_pin_o,
    // power
    output rmsfc_pkg::rmsfc_pwr_type         pwr_en_o,
    // serial port selects
    input  wire logic                        config_port_select_n_i,
    input  wire logic                        fifo_port_select_n_i,
    output logic                             sdo_oe_o,
    output logic                             cfg_access_o,
    // host and modulator buffer access
    input  wire logic                        host_wr_i,
    input  wire logic [7:0]                  host_wr_data_i,
    input  wire logic                        host_rd_i,
    output logic [7:0]                       host_rd_data_o,
    input  wire logic                        mod_pull_i,
    output logic [7:0]                       mod_byte_o,
    // buffer status
    output logic [6:0]                       buffer_count_o,
    output logic                             buffer_nonempty_flag_o,
    output logic                             buffer_full_flag_o,
    output logic                             rx_level_event_o,
    output logic                             tx_level_event_o,
    // pins
    output logic                             interrupt_pin_a_o,
    output logic                             interrupt_pin_a_oe_o,
    output logic                             interrupt_pin_b_o,
    output logic                             interrupt_pin_b_oe_o,
    output logic                             clock_output_pin_oe_o,
    // link domain, except data_pin_oe_o which is registered on core_clk_i
    input  wire logic                        demod_bit_i,
    input  wire logic                        data_pin_i,
    output logic                             data_pin_o,
    output logic                             data_pin_oe_o,
    output logic                             mod_bit_o
);
    if (DEPTH != rmsfc_pkg::FIFO_WORDS)
    begin
        $error("depth must be 64");
    end

    // mode register
    logic [2:0] mode_ff;
    logic [1:0] dmode_ff;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_ff  <= rmsfc_pkg::RST_MODE;
            dmode_ff <= rmsfc_pkg::RST_DMODE;
        end
        else
        begin
            mode_ff  <= chip_level_mode_i; // RQ25
            dmode_ff <= data_handling_mode_i;
        end
    end

    logic is_sleep, is_recv, is_xmit, is_cont, is_buf, is_pkt;
    assign is_recv = (mode_ff == rmsfc_pkg::RMSFC_RECV); // RQ9
    assign is_xmit = (mode_ff == rmsfc_pkg::RMSFC_XMIT);
    assign is_sleep = (mode_ff == rmsfc_pkg::RMSFC_SLEEP) || (mode_ff > 3'h4);
    assign is_cont = (dmode_ff == rmsfc_pkg::RMSFC_CONT); // RQ22
    assign is_buf = (dmode_ff == rmsfc_pkg::RMSFC_BUFF); // RQ23
    assign is_pkt = (dmode_ff == rmsfc_pkg::RMSFC_PACKET);

    // power enables
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            pwr_en_o <= '0;
        else
        begin
            pwr_en_o.xtal  <= !is_sleep; // RQ10
            pwr_en_o.synth <= !is_sleep && (mode_ff != rmsfc_pkg::RMSFC_STANDBY);
            pwr_en_o.recv  <= is_recv;
            pwr_en_o.xmit  <= is_xmit;
        end
    end

    // band and quarter decode
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            band_onehot_o    <= '0;
            quarter_onehot_o <= '0;
        end
        else
        begin
            band_onehot_o <= '0;
            if (vco_band_select_i <= rmsfc_pkg::BAND_LAST)
                band_onehot_o[vco_band_select_i] <= 1'b1; // RQ1
            quarter_onehot_o <= 4'h1 << vco_quarter_select_i; // RQ2
        end
    end

    // divider sets; hopping relies on the host loading the idle set first
    rmsfc_pkg::rmsfc_div_set_type sel_div;
    assign sel_div = divider_set_select_i ? div_set_b_i : div_set_a_i; // RQ5 RQ6
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            active_div_o   <= '0;
            fb_ratio_o     <= '0;
            div_range_ok_o <= 1'b0;
        end
        else
        begin
            active_div_o <= sel_div;
            // feedback multiple 75*(p+1)+s; lo = xtal*fb/(r+1), if = lo/8
            fb_ratio_o <= 16'(rmsfc_pkg::P_MULT * (16'(sel_div.p) + 16'h1)
                          + 16'(sel_div.s)); // RQ3 RQ4
            div_range_ok_o <= (sel_div.r >= rmsfc_pkg::R_MIN)
                              && (sel_div.r <= rmsfc_pkg::R_MAX)
                              && (sel_div.s <= sel_div.p); // RQ3
        end
    end

    // lock synchroniser and sticky status
    logic lock_s1_ff, lock_s2_ff, lock_s3_ff;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
            lock_s3_ff <= 1'b0;
        end
        else
        begin
            lock_s1_ff <= pll_lock_raw_i;
            lock_s2_ff <= lock_s1_ff;
            lock_s3_ff <= lock_s2_ff;
        end
    end
    logic lock_rise;
    assign lock_rise = lock_s2_ff && !lock_s3_ff;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            lock_status_latch_o <= 1'b0;
        else if (lock_rise)
            lock_status_latch_o <= 1'b1; // RQ8
        else if (lock_status_clear_i)
            lock_status_latch_o <= 1'b0; // RQ8
    end
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            lock_pin_o <= 1'b0;
        else
            lock_pin_o <= lock_pin_enable_i && lock_s2_ff; // RQ7
    end

    // serial select pins
    logic cs_s1_ff, cs_s2_ff, fs_s1_ff, fs_s2_ff;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            fs_s1_ff <= 1'b1;
            fs_s2_ff <= 1'b1;
        end
        else
        begin
            cs_s1_ff <= config_port_select_n_i;
            cs_s2_ff <= cs_s1_ff;
            fs_s1_ff <= fifo_port_select_n_i;
            fs_s2_ff <= fs_s1_ff;
        end
    end
    logic fifo_access;
    assign sdo_oe_o = !cs_s2_ff || !fs_s2_ff; // RQ12
    assign cfg_access_o = !cs_s2_ff; // RQ13
    assign fifo_access = cs_s2_ff && !fs_s2_ff; // RQ13

    // link reset and mode levels into the link domain
    logic lrst_s1_ff, lrst_s2_ff, lcont_s1_ff, lcont_s2_ff;
    logic lfill_s1_ff, lfill_s2_ff;
    logic fill_lvl;
    assign fill_lvl = is_recv && (is_buf || is_pkt); // RQ15 RQ16
    always_ff @(posedge link_clk_i)
    begin
        lrst_s1_ff  <= rst_n_i;
        lrst_s2_ff  <= lrst_s1_ff;
        lcont_s1_ff <= is_cont;
        lcont_s2_ff <= lcont_s1_ff;
        lfill_s1_ff <= fill_lvl;
        lfill_s2_ff <= lfill_s1_ff;
    end

    // link side: bypass and byte assembly
    logic [7:0] lshift_ff;
    logic [2:0] lbit_ff;
    logic [7:0] lbyte_ff;
    logic       ltgl_ff;
    logic       din_s1_ff;
    always_ff @(posedge link_clk_i)
    begin
        if (!lrst_s2_ff)
        begin
            data_pin_o <= 1'b0;
            din_s1_ff  <= 1'b0;
            mod_bit_o  <= 1'b0;
        end
        else
        begin
            data_pin_o <= demod_bit_i; // RQ14
            din_s1_ff  <= data_pin_i;
            mod_bit_o  <= lcont_s2_ff ? din_s1_ff : 1'b0; // RQ14 RQ17
        end
    end
    always_ff @(posedge link_clk_i)
    begin
        if (!lrst_s2_ff || !lfill_s2_ff)
        begin
            lshift_ff <= '0;
            lbit_ff   <= '0;
            lbyte_ff  <= '0;
            ltgl_ff   <= 1'b0;
        end
        else
        begin
            lshift_ff <= {lshift_ff[6:0], demod_bit_i};
            lbit_ff   <= lbit_ff + 3'h1;
            if (lbit_ff == 3'(rmsfc_pkg::BITS_PER_BYTE - 1))
            begin
                lbyte_ff <= {lshift_ff[6:0], demod_bit_i}; // RQ15
                ltgl_ff  <= !ltgl_ff;
            end
        end
    end

    // byte event crossing; the byte is steady for eight link clocks
    logic tg_s1_ff, tg_s2_ff, tg_s3_ff;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            tg_s1_ff <= 1'b0;
            tg_s2_ff <= 1'b0;
            tg_s3_ff <= 1'b0;
        end
        else
        begin
            tg_s1_ff <= ltgl_ff;
            tg_s2_ff <= tg_s1_ff;
            tg_s3_ff <= tg_s2_ff;
        end
    end

    // buffer
    logic [7:0] mem [DEPTH];
    logic [5:0] wp_ff, rp_ff;
    logic [6:0] cnt_ff;
    logic [6:0] depth_lim;
    logic push, pop;
    logic [7:0] push_data;
    assign depth_lim = 7'(rmsfc_pkg::DEPTH_STEP * (7'(buffer_working_depth_i) + 7'h1)); // RQ18
    assign buffer_full_flag_o = (cnt_ff >= depth_lim); // RQ21 RQ24
    assign buffer_nonempty_flag_o = (cnt_ff != 7'h0); // RQ21 RQ24
    assign buffer_count_o = cnt_ff;
    always_comb
    begin
        push      = 1'b0;
        push_data = host_wr_data_i;
        pop       = 1'b0;
        if (fill_lvl && (tg_s2_ff != tg_s3_ff))
        begin
            push      = 1'b1; // RQ15
            push_data = lbyte_ff;
        end
        else if (is_xmit && !is_cont && fifo_access && host_wr_i)
            push = 1'b1; // RQ15
        if (is_recv && fifo_access && host_rd_i)
            pop = 1'b1;
        else if (is_xmit && !is_cont && mod_pull_i)
            pop = 1'b1;
        if (buffer_full_flag_o && !pop)
            push = 1'b0;
        if (!buffer_nonempty_flag_o)
            pop = 1'b0;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (push)
            mem[wp_ff] <= push_data;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i || is_cont)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wp_ff <= wp_ff + 6'h1;
            if (pop)
                rp_ff <= rp_ff + 6'h1;
            cnt_ff <= cnt_ff + 7'(push) - 7'(pop);
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            host_rd_data_o <= '0;
            mod_byte_o     <= '0;
        end
        else if (pop)
        begin
            if (is_recv)
                host_rd_data_o <= mem[rp_ff];
            else
                mod_byte_o <= mem[rp_ff];
        end
    end

    // threshold events as rising edges of level compares
    logic rx_lvl_ff, tx_lvl_ff;
    logic rx_lvl, tx_lvl;
    assign rx_lvl = (cnt_ff >= 7'(buffer_level_threshold_i)); // RQ19
    assign tx_lvl = (cnt_ff <= 7'(buffer_level_threshold_i)); // RQ20
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rx_lvl_ff        <= 1'b1;
            tx_lvl_ff        <= 1'b1;
            rx_level_event_o <= 1'b0;
            tx_level_event_o <= 1'b0;
        end
        else
        begin
            rx_lvl_ff        <= rx_lvl;
            tx_lvl_ff        <= tx_lvl;
            rx_level_event_o <= rx_lvl && !rx_lvl_ff; // RQ19
            tx_level_event_o <= tx_lvl && !tx_lvl_ff; // RQ20
        end
    end

    // pins
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            interrupt_pin_a_o     <= 1'b0;
            interrupt_pin_b_o     <= 1'b0;
            interrupt_pin_a_oe_o  <= 1'b0;
            interrupt_pin_b_oe_o  <= 1'b0;
            clock_output_pin_oe_o <= 1'b0;
            data_pin_oe_o         <= 1'b0;
        end
        else
        begin
            interrupt_pin_a_o     <= is_xmit ? tx_lvl : rx_lvl;
            interrupt_pin_b_o     <= is_xmit ? buffer_nonempty_flag_o
                                             : buffer_full_flag_o;
            interrupt_pin_a_oe_o  <= !is_sleep; // RQ11
            interrupt_pin_b_oe_o  <= !is_sleep; // RQ11
            clock_output_pin_oe_o <= !is_sleep; // RQ11
            data_pin_oe_o         <= is_recv; // RQ11 RQ17
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_MODE_TWO: assert property (chip_level_mode_i == 3'h4 ##2 1'b1 |-> // RQ25
        pwr_en_o.xmit || $past(chip_level_mode_i) != 3'h4)
        else $error("transmit power late");
    AST_PWR: assert property (pwr_en_o.recv || pwr_en_o.xmit |-> // RQ10
        pwr_en_o.xtal && pwr_en_o.synth)
        else $error("power enables inconsistent");
    AST_LOCK_STICKY: assert property (lock_status_latch_o && !lock_status_clear_i // RQ8
        |=> lock_status_latch_o)
        else $error("lock status dropped");
    AST_LOCK_SET: assert property (lock_rise |=> lock_status_latch_o) // RQ8
        else $error("lock rise lost");
    AST_LOCK_PIN: assert property (lock_pin_o |-> $past(lock_pin_enable_i)) // RQ7
        else $error("lock pin without enable");
    AST_SDO: assert property (cs_s2_ff && fs_s2_ff |-> !sdo_oe_o) // RQ12
        else $error("serial out driven unselected");
    AST_PRIO: assert property (!cs_s2_ff |-> !fifo_access) // RQ13
        else $error("buffer access under config");
    AST_FULL: assert property (buffer_full_flag_o && !pop |=> // RQ24
        cnt_ff == $past(cnt_ff))
        else $error("write into full buffer");
    AST_DEPTH: assert property (cnt_ff <= depth_lim || $changed(buffer_working_depth_i)) // RQ18
        else $error("count beyond depth");
    AST_RXEV: assert property (rx_level_event_o |-> // RQ19
        $past(cnt_ff) >= 7'($past(buffer_level_threshold_i)))
        else $error("rx level event wrong");
    AST_SLEEP: assert property (pwr_en_o == '0 ##1 pwr_en_o == '0 |-> // RQ11
        !data_pin_oe_o && !interrupt_pin_a_oe_o)
        else $error("pins driven in sleep");
    AST_DIV: assert property (divider_set_select_i ##1 divider_set_select_i // RQ5
        |-> active_div_o == $past(div_set_b_i))
        else $error("wrong divider set");

    COV_FULL: cover property (buffer_full_flag_o);
    COV_HOP: cover property ($changed(divider_set_select_i));
    COV_RXPUSH: cover property (fill_lvl && push);
    COV_LOCK: cover property (lock_rise ##[1:20] lock_status_clear_i);
endmodule
`default_nettype wire

/* tb/rmsfc_link_model.sv */
// behavioural demodulator and transmit data source at the link side
// assumes the bench calls send once per frame; the link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module rmsfc_link_model (
    // link side
    output logic link_clk_o,
    output logic demod_bit_o,
    output logic data_pin_o
);
    initial
    begin
        link_clk_o = 1'b0;
        demod_bit_o = 1'b0;
    end
    assign data_pin_o = demod_bit_o;
    // one byte msb first, 32 ns bit period, clock idle low
    task automatic send(input logic [7:0] b, input int nb = 8);
        #3;
        for (int i = 7; i > 7 - nb; i--)
        begin
            demod_bit_o = b[i];
            #16 link_clk_o = 1'b1;
            #16 link_clk_o = 1'b0;
        end
        // released line shows the inverse of the last bit
        demod_bit_o = ~demod_bit_o;
    endtask
endmodule
`default_nettype wire

/* tb/radio_mode_synth_fifo_control_test.sv */
// self-checking bench for the radio mode, synthesizer and buffer control block
// assumes the link model beside it and the buffer parameter left at 64
`timescale 1ns/1ps
`default_nettype none
module radio_mode_synth_fifo_control_test;
    logic core_clk_i, rst_n_i, divider_set_select_i, lock_pin_enable_i, lock_status_clear_i;
    logic pll_lock_raw_i, config_port_select_n_i, fifo_port_select_n_i, host_wr_i, host_rd_i;
    logic mod_pull_i, link_clk_i, demod_bit_i, data_pin_i;
    logic [2:0] chip_level_mode_i, vco_band_select_i;
    logic [1:0] data_handling_mode_i, vco_quarter_select_i, buffer_working_depth_i;
    logic [5:0] buffer_level_threshold_i, band_onehot_o;
    logic [7:0] host_wr_data_i, host_rd_data_o, mod_byte_o;
    rmsfc_pkg::rmsfc_div_set_type div_set_a_i, div_set_b_i, active_div_o;
    rmsfc_pkg::rmsfc_pwr_type pwr_en_o;
    logic [3:0] quarter_onehot_o;
    logic [15:0] fb_ratio_o;
    logic [6:0] buffer_count_o;
    logic div_range_ok_o, lock_status_latch_o, lock_pin_o, sdo_oe_o, cfg_access_o;
    logic buffer_nonempty_flag_o, buffer_full_flag_o, rx_level_event_o, tx_level_event_o;
    logic interrupt_pin_a_o, interrupt_pin_a_oe_o, interrupt_pin_b_o, interrupt_pin_b_oe_o;
    logic clock_output_pin_oe_o, data_pin_o, data_pin_oe_o, mod_bit_o;
    int n_fail = 0;
    int checks_done = 0;
    int n_rx = 0;
    int n_tx = 0;
    int cycles = 0;
    logic [7:0] q [$];
    logic [7:0] rtab [4];

    rmsfc_ctrl #(.DEPTH(64)) rmsfc_ctrl_i (
        .core_clk_i, .rst_n_i, .link_clk_i, .chip_level_mode_i, .data_handling_mode_i,
        .vco_band_select_i, .vco_quarter_select_i, .div_set_a_i, .div_set_b_i,
        .divider_set_select_i, .lock_pin_enable_i, .lock_status_clear_i,
        .buffer_working_depth_i, .buffer_level_threshold_i, .pll_lock_raw_i, .band_onehot_o,
        .quarter_onehot_o, .active_div_o, .fb_ratio_o, .div_range_ok_o, .lock_status_latch_o,
        .lock_pin_o, .pwr_en_o, .config_port_select_n_i, .fifo_port_select_n_i, .sdo_oe_o,
        .cfg_access_o, .host_wr_i, .host_wr_data_i, .host_rd_i, .host_rd_data_o, .mod_pull_i,
        .mod_byte_o, .buffer_count_o, .buffer_nonempty_flag_o, .buffer_full_flag_o,
        .rx_level_event_o, .tx_level_event_o, .interrupt_pin_a_o, .interrupt_pin_a_oe_o,
        .interrupt_pin_b_o, .interrupt_pin_b_oe_o, .clock_output_pin_oe_o, .demod_bit_i,
        .data_pin_i, .data_pin_o, .data_pin_oe_o, .mod_bit_o
    );
    rmsfc_link_model rmsfc_link_model_i (
        .link_clk_o  (link_clk_i),
        .demod_bit_o (demod_bit_i),
        .data_pin_o  (data_pin_i)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // {xtal, synth, recv, xmit, irq a oe, irq b oe, clock_output_pin oe, data oe}
    function automatic logic [31:0] mode_exp(input logic [2:0] m);
        logic on;
        on = (m != 3'h0) && (m <= 3'h4);
        return {24'h0, on, on && m != 3'h1, m == 3'h3, m == 3'h4, on, on, on, m == 3'h3};
    endfunction

    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // level event pulses and the run ceiling
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (rx_level_event_o === 1'b1)
            n_rx++;
        if (tx_level_event_o === 1'b1)
            n_tx++;
        if (cycles == 6000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    initial
    begin
        logic [2:0] c;
        logic [7:0] b;
        rmsfc_pkg::rmsfc_div_set_type d;
        rmsfc_pkg::rmsfc_div_set_type prev;
        void'($urandom(95667));
        rtab = '{8'h3f, 8'h40, 8'ha9, 8'haa};
        {chip_level_mode_i, data_handling_mode_i, vco_band_select_i, vco_quarter_select_i} = '0;
        {div_set_a_i, div_set_b_i, divider_set_select_i, lock_pin_enable_i} = '0;
        {lock_status_clear_i, buffer_working_depth_i, buffer_level_threshold_i} = '0;
        {pll_lock_raw_i, host_wr_i, host_wr_data_i, host_rd_i, mod_pull_i} = '0;
        config_port_select_n_i = 1'b1;
        fifo_port_select_n_i = 1'b1;
        rst_n_i = 1'b0;
        cyc(5);
        // link reset needs link edges while reset is low
        rmsfc_link_model_i.send(8'h00);
        cyc(1);
        rst_n_i = 1'b1;
        cyc(1);
        check(32'({pwr_en_o, buffer_count_o, buffer_full_flag_o, lock_status_latch_o}), 0);
        rmsfc_link_model_i.send(8'h00);
        prev = '0;
        for (int m = 0; m < 8; m++)
        begin
            chip_level_mode_i = 3'(m);
            cyc(2);
            check(32'({pwr_en_o, interrupt_pin_a_oe_o, interrupt_pin_b_oe_o,
                clock_output_pin_oe_o, data_pin_oe_o}), mode_exp(3'(m)));
        end
        for (int i = 0; i < 16; i++)
        begin
            c = (i < 8) ? 3'(i) : 3'($urandom);
            vco_band_select_i = c;
            vco_quarter_select_i = 2'($urandom);
            cyc(1);
            check(32'(band_onehot_o), (c < 3'h6) ? 32'h1 << c : 32'h0);
            check(32'(quarter_onehot_o), 32'h1 << vco_quarter_select_i);
        end
        for (int i = 0; i < 12; i++)
        begin
            d = 24'($urandom);
            if (i < 4)
                d.r = rtab[i];
            if (i == 5)
                d.s = d.p;
            if (i == 6)
                d.s = d.p + 8'h01;
            if (divider_set_select_i)
                div_set_a_i = d;
            else
                div_set_b_i = d;
            cyc(2);
            check(32'(active_div_o), 32'(prev));
            divider_set_select_i = ~divider_set_select_i;
            cyc(2);
            check(32'(active_div_o), 32'(d));
            check(32'(fb_ratio_o), 32'h4b * (32'(d.p) + 32'h1) + 32'(d.s));
            check(32'(div_range_ok_o), 32'(d.r >= 8'h40 && d.r <= 8'ha9 && d.s <= d.p));
            prev = d;
        end
        pll_lock_raw_i = 1'b1;
        cyc(4);
        check(32'({lock_status_latch_o, lock_pin_o}), 32'h2);
        lock_pin_enable_i = 1'b1;
        cyc(2);
        check(32'(lock_pin_o), 32'h1);
        pll_lock_raw_i = 1'b0;
        cyc(4);
        check(32'({lock_status_latch_o, lock_pin_o}), 32'h2);
        lock_status_clear_i = 1'b1;
        cyc(1);
        lock_status_clear_i = 1'b0;
        cyc(1);
        check(32'(lock_status_latch_o), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            {config_port_select_n_i, fifo_port_select_n_i} = 2'(i);
            cyc(3);
            check(32'({sdo_oe_o, cfg_access_o}), 32'({i != 3, i < 2}));
        end
        chip_level_mode_i = 3'h4;
        data_handling_mode_i = 2'h1;
        {config_port_select_n_i, fifo_port_select_n_i} = 2'h0;
        cyc(3);
        host_wr_i = 1'b1;
        cyc(4);
        host_wr_i = 1'b0;
        cyc(2);
        check(32'(buffer_count_o), 32'h0);
        config_port_select_n_i = 1'b1;
        for (int dp = 0; dp < 4; dp++)
        begin
            buffer_working_depth_i = 2'(dp);
            data_handling_mode_i = (dp == 0) ? 2'h2 : 2'h1;
            buffer_level_threshold_i = 6'(1 + $urandom % 15);
            cyc(3);
            n_rx = 0;
            n_tx = 0;
            host_wr_i = 1'b1;
            for (int k = 0; k <= 16 * (dp + 1); k++)
            begin
                host_wr_data_i = 8'($urandom);
                q.push_back(host_wr_data_i);
                cyc(1);
            end
            host_wr_i = 1'b0;
            void'(q.pop_back());
            cyc(3);
            check(32'({buffer_count_o, buffer_full_flag_o, buffer_nonempty_flag_o,
                interrupt_pin_b_o, interrupt_pin_a_o}),
                32'({7'(16 * (dp + 1)), 4'he}));
            mod_pull_i = 1'b1;
            while (q.size() > 0)
            begin
                cyc(1);
                check(32'(mod_byte_o), 32'(q.pop_front()));
            end
            mod_pull_i = 1'b0;
            cyc(3);
            check(32'({buffer_count_o, buffer_full_flag_o, buffer_nonempty_flag_o}), 0);
            check(32'({8'(n_rx), 8'(n_tx)}), 32'h0101);
        end
        chip_level_mode_i = 3'h3;
        cyc(20);
        rmsfc_link_model_i.send(8'h0, 2);
        for (int k = 0; k < 3; k++)
        begin
            b = 8'($urandom);
            q.push_back(b);
            rmsfc_link_model_i.send(b);
            cyc(8);
        end
        check(32'(buffer_count_o), 32'h3);
        host_rd_i = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            cyc(1);
            if (k < 3)
                check(32'(host_rd_data_o), 32'(q.pop_front()));
        end
        host_rd_i = 1'b0;
        cyc(2);
        check(32'(buffer_count_o), 32'h0);
        data_handling_mode_i = 2'h0;
        cyc(20);
        b = 8'($urandom);
        fork
            rmsfc_link_model_i.send(b);
            for (int k = 7; k >= 0; k--)
            begin
                @(posedge link_clk_i);
                #1;
                check(32'(data_pin_o), 32'(b[k]));
            end
        join
        cyc(12);
        check(32'({buffer_count_o, data_pin_oe_o, mod_bit_o}), 32'({2'h1, b[1]}));
        give_verdict();
    end
endmodule
`default_nettype wire
